//--- rtl/par_pkg.sv
// Constants shared by the private address resolver: register map, fields, timing.
// Assumes a 40 MHz system clock and a 4 KB register window on the bus.
package par_pkg;
    // Register offsets inside the 4 KB window
    localparam logic [11:0] OFS_START = 12'h000;
    localparam logic [11:0] OFS_STOP = 12'h004;
    localparam logic [11:0] OFS_EV_DONE = 12'h100;
    localparam logic [11:0] OFS_EV_MATCH = 12'h104;
    localparam logic [11:0] OFS_EV_NOMATCH = 12'h108;
    localparam logic [11:0] OFS_INT_ARM = 12'h304;
    localparam logic [11:0] OFS_INT_DIS = 12'h308;
    localparam logic [11:0] OFS_STATUS = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
    localparam logic [11:0] OFS_KEY_PTR = 12'h508;
    localparam logic [11:0] OFS_ADDR_PTR = 12'h510;
    localparam logic [11:0] OFS_WORK_PTR = 12'h514;
    // Event and interrupt bit positions
    localparam int EV_DONE_BIT = 0;
    localparam int EV_MATCH_BIT = 1;
    localparam int EV_NOMATCH_BIT = 2;
    // Field values and reset values
    localparam logic [1:0] ENABLE_ON = 2'h3;
    localparam logic [1:0] ENABLE_RST = 2'h0;
    localparam logic [4:0] KEY_COUNT_RST = 5'h01;
    localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;
    localparam logic [31:0] KEY_STRIDE = 32'h0000_0010;
    localparam logic [3:0] WORK_SEL = 4'h7;
    localparam logic [3:0] FULL_SEL = 4'hf;
    localparam int CHECK_ROUNDS = 16;
    // Timing: per-key and fixed overhead, in ns, converted to 40 MHz cycles
    localparam int CLK_MHZ = 40;
    localparam int T_KEY_NS = 6100;
    localparam int T_OVH_NS = 1000;
    localparam int KEY_CYC = T_KEY_NS * CLK_MHZ / 1000;
    localparam int OVH_CYC = T_OVH_NS * CLK_MHZ / 1000;
    // Resolution sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ADDR0,
        ST_RD_ADDR1,
        ST_WR_WORK,
        ST_RD_KEY,
        ST_CHECK
    } par_state_e;
endpackage

//--- rtl/par_mem_if.sv
// Word request channel between the resolver sequencer and its memory port.
// Assumes one request at a time; req is a one-cycle pulse, done answers it.
`timescale 1ns/10ps
interface par_mem_if;
    logic req;
    logic we;
    logic [3:0] sel;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    modport ctrl (output req, output we, output sel, output addr, output wdata,
                  input rdata, input done);
    modport port (input req, input we, input sel, input addr, input wdata,
                  output rdata, output done);
endinterface

//--- rtl/par_mem_port.sv
// Memory master port of the resolver: turns one request pulse into a held
// cycle on the system memory bus. Assumes memory answers with an ack pulse.
`timescale 1ns/10ps
module par_mem_port
    import par_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    par_mem_if.port mp,
    output logic mem_cyc_o,
    output logic mem_we_o,
    output logic [3:0] mem_sel_o,
    output logic [31:0] mem_adr_o,
    output logic [31:0] mem_dat_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_dat_i
);
    // Bus cycle held from the request until the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_cyc_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_sel_o <= 4'h0;
            mem_adr_o <= 32'h0000_0000;
            mem_dat_o <= 32'h0000_0000;
            mp.done <= 1'b0;
            mp.rdata <= 32'h0000_0000;
        end
        else
        begin
            mp.done <= 1'b0;
            if (!mem_cyc_o && mp.req)
            begin
                mem_cyc_o <= 1'b1;
                mem_we_o <= mp.we;
                mem_sel_o <= mp.sel;
                mem_adr_o <= mp.addr;
                mem_dat_o <= mp.wdata;
            end
            else if (mem_cyc_o && mem_ack_i)
            begin
                mem_cyc_o <= 1'b0;
                mem_we_o <= 1'b0;
                mp.done <= 1'b1;
                mp.rdata <= mem_dat_i;
            end
        end
    end
endmodule

//--- rtl/par_key_check.sv
// Keyed hash of the random part of an address under one identity root key.
// Stand-in for the shared cipher core; iterates ROUNDS cycles per key.
`timescale 1ns/10ps
module par_key_check
    import par_pkg::*;
#(
    parameter int ROUNDS = CHECK_ROUNDS
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [127:0] key_i,
    input wire logic [23:0] prand_i,
    output logic done_o,
    output logic [23:0] hash_o
);
    logic [31:0] s_q;
    logic [4:0] rnd_q;
    logic busy_q;

    // One mixing round: rotate plus keyed xor
    function automatic logic [31:0] mix(input logic [31:0] s, input logic [31:0] k);
        mix = {s[26:0], s[31:27]} + (s ^ k);
    endfunction

    // Round iteration, key words taken in turn
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= 32'h0000_0000;
            rnd_q <= 5'h00;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                s_q <= {8'h00, prand_i} ^ key_i[31:0];
                rnd_q <= 5'h00;
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                s_q <= mix(s_q, key_i[{rnd_q[1:0], 5'h00} +: 32]);
                rnd_q <= rnd_q + 5'h01;
                if (rnd_q == 5'(ROUNDS - 1))
                begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

    assign hash_o = s_q[23:0];
endmodule

//--- rtl/par_resolver.sv
// Private address resolver: Wishbone register slave, resolution sequencer,
// event flags and interrupt. Assumes memory holds the key table and address.
`timescale 1ns/10ps
module par_resolver
    import par_pkg::*;
#(
    parameter int KEY_ROUNDS = CHECK_ROUNDS
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic mem_cyc_o,
    output logic mem_we_o,
    output logic [3:0] mem_sel_o,
    output logic [31:0] mem_adr_o,
    output logic [31:0] mem_dat_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_dat_i
);
    par_mem_if mp ();

    logic [1:0] enable_q;
    logic [4:0] key_count_q;
    logic [31:0] key_ptr_q;
    logic [31:0] addr_ptr_q;
    logic [31:0] work_ptr_q;
    logic [2:0] mask_q;
    logic [2:0] ev_q;
    logic [2:0] ev_set_q;
    logic [3:0] status_q;
    par_state_e st_q;
    logic wait_q;
    logic req_q;
    logic we_q;
    logic [3:0] sel_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] addr_lo_q;
    logic [15:0] addr_hi_q;
    logic [31:0] kw_q [0:3];
    logic [3:0] key_idx_q;
    logic [1:0] word_idx_q;
    logic chk_start_q;
    logic chk_done;
    logic [23:0] chk_hash;
    logic [15:0] key_cyc_q;
    logic [15:0] run_cyc_q;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] rd_data;
    logic run_en;
    logic start_w;
    logic stop_w;
    logic abort_w;
    logic mem_st;
    logic [31:0] step_addr;
    logic [4:0] keys_eff;
    logic [23:0] prand;

    // Byte-lane mask from Wishbone select
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Register index match, low address bits ignored
    function automatic logic hit(input logic [31:0] adr, input logic [11:0] ofs);
        hit = (adr[11:2] == ofs[11:2]);
    endfunction

    // Out-of-range key counts are clamped so the walk stays inside the table
    function automatic logic [4:0] clamp_keys(input logic [4:0] k);
        if (k == 5'h00)
            clamp_keys = 5'h01;
        else if (k > KEY_COUNT_MAX)
            clamp_keys = KEY_COUNT_MAX;
        else
            clamp_keys = k;
    endfunction

    // Writes land at the edge where the master sees ack
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wmask = lane_mask(wb_sel_i);
    assign run_en = (enable_q == ENABLE_ON);
    assign start_w = wr_en && hit(wb_adr_i, OFS_START) && wb_sel_i[0] && wb_dat_i[0];
    assign stop_w = wr_en && hit(wb_adr_i, OFS_STOP) && wb_sel_i[0] && wb_dat_i[0];
    assign abort_w = stop_w || !run_en;
    assign keys_eff = clamp_keys(key_count_q);
    assign prand = {addr_hi_q, addr_lo_q[31:24]};

    // Wishbone handshake: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) ? rd_data
                                                                          : 32'h0000_0000;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit(wb_adr_i, OFS_EV_DONE))
            rd_data = {31'h0, ev_q[EV_DONE_BIT]};
        else if (hit(wb_adr_i, OFS_EV_MATCH))
            rd_data = {31'h0, ev_q[EV_MATCH_BIT]};
        else if (hit(wb_adr_i, OFS_EV_NOMATCH))
            rd_data = {31'h0, ev_q[EV_NOMATCH_BIT]};
        else if (hit(wb_adr_i, OFS_INT_ARM) || hit(wb_adr_i, OFS_INT_DIS))
            rd_data = {29'h0, mask_q};
        else if (hit(wb_adr_i, OFS_STATUS))
            rd_data = {28'h0, status_q};
        else if (hit(wb_adr_i, OFS_ENABLE))
            rd_data = {30'h0, enable_q};
        else if (hit(wb_adr_i, OFS_KEY_COUNT))
            rd_data = {27'h0, key_count_q};
        else if (hit(wb_adr_i, OFS_KEY_PTR))
            rd_data = key_ptr_q;
        else if (hit(wb_adr_i, OFS_ADDR_PTR))
            rd_data = addr_ptr_q;
        else if (hit(wb_adr_i, OFS_WORK_PTR))
            rd_data = work_ptr_q;
    end

    // Configuration registers, byte lanes honoured
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            enable_q <= ENABLE_RST;
            key_count_q <= KEY_COUNT_RST;
            key_ptr_q <= PTR_RST;
            addr_ptr_q <= PTR_RST;
            work_ptr_q <= PTR_RST;
        end
        else if (wr_en)
        begin
            if (hit(wb_adr_i, OFS_ENABLE) && wb_sel_i[0])
                enable_q <= wb_dat_i[1:0];
            if (hit(wb_adr_i, OFS_KEY_COUNT) && wb_sel_i[0])
                key_count_q <= wb_dat_i[4:0];
            if (hit(wb_adr_i, OFS_KEY_PTR))
                key_ptr_q <= (key_ptr_q & ~wmask) | (wb_dat_i & wmask);
            if (hit(wb_adr_i, OFS_ADDR_PTR))
                addr_ptr_q <= (addr_ptr_q & ~wmask) | (wb_dat_i & wmask);
            if (hit(wb_adr_i, OFS_WORK_PTR))
                work_ptr_q <= (work_ptr_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // Interrupt mask: arm sets, disable clears, zeros leave bits alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_q <= MASK_RST;
        else if (wr_en && wb_sel_i[0])
        begin
            if (hit(wb_adr_i, OFS_INT_ARM))
                mask_q <= mask_q | wb_dat_i[2:0];
            else if (hit(wb_adr_i, OFS_INT_DIS))
                mask_q <= mask_q & ~wb_dat_i[2:0];
        end
    end

    // Sticky events, write one to clear; a same-cycle set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_q <= 3'h0;
        else
        begin
            logic [2:0] clr;
            clr = 3'h0;
            if (wr_en && wb_sel_i[0] && wb_dat_i[0])
            begin
                clr[EV_DONE_BIT] = hit(wb_adr_i, OFS_EV_DONE);
                clr[EV_MATCH_BIT] = hit(wb_adr_i, OFS_EV_MATCH);
                clr[EV_NOMATCH_BIT] = hit(wb_adr_i, OFS_EV_NOMATCH);
            end
            ev_q <= (ev_q & ~clr) | ev_set_q;
        end
    end

    // Level interrupt while any unmasked event is pending
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(ev_q & mask_q);
    end

    // Address of the memory step for the current state
    always_comb
    begin
        mem_st = 1'b1;
        step_addr = 32'h0000_0000;
        case (st_q)
            ST_RD_ADDR0: step_addr = addr_ptr_q;
            ST_RD_ADDR1: step_addr = addr_ptr_q + 32'h0000_0004;
            ST_WR_WORK: step_addr = work_ptr_q;
            ST_RD_KEY: step_addr = key_ptr_q + (KEY_STRIDE * {28'h0, key_idx_q})
                                   + {28'h0, word_idx_q, 2'b00};
            default: mem_st = 1'b0;
        endcase
    end

    // Resolution sequencer; memory requests only go out while enabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            wait_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            sel_q <= FULL_SEL;
            addr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            addr_lo_q <= 32'h0000_0000;
            addr_hi_q <= 16'h0000;
            key_idx_q <= 4'h0;
            word_idx_q <= 2'h0;
            chk_start_q <= 1'b0;
            ev_set_q <= 3'h0;
            status_q <= STATUS_RST;
            for (int i = 0; i < 4; i++)
                kw_q[i] <= 32'h0000_0000;
        end
        else
        begin
            req_q <= 1'b0;
            chk_start_q <= 1'b0;
            ev_set_q <= 3'h0;
            if (mem_st && !wait_q)
            begin
                if (abort_w)
                    st_q <= ST_IDLE;
                else
                begin
                    req_q <= 1'b1;
                    wait_q <= 1'b1;
                    addr_q <= step_addr;
                    we_q <= (st_q == ST_WR_WORK);
                    sel_q <= (st_q == ST_WR_WORK) ? WORK_SEL : FULL_SEL;
                    wdata_q <= {8'h00, prand};
                end
            end
            else if (mem_st && mp.done)
            begin
                wait_q <= 1'b0;
                case (st_q)
                    ST_RD_ADDR0:
                    begin
                        addr_lo_q <= mp.rdata;
                        st_q <= ST_RD_ADDR1;
                    end
                    ST_RD_ADDR1:
                    begin
                        addr_hi_q <= mp.rdata[15:0];
                        st_q <= ST_WR_WORK;
                    end
                    ST_WR_WORK: st_q <= ST_RD_KEY;
                    default:
                    begin
                        kw_q[word_idx_q] <= mp.rdata;
                        word_idx_q <= word_idx_q + 2'h1;
                        if (word_idx_q == 2'h3)
                        begin
                            st_q <= ST_CHECK;
                            chk_start_q <= 1'b1;
                        end
                    end
                endcase
            end
            else
            begin
                case (st_q)
                    ST_IDLE:
                        if (start_w && run_en)
                        begin
                            st_q <= ST_RD_ADDR0;
                            key_idx_q <= 4'h0;
                            word_idx_q <= 2'h0;
                        end
                    ST_CHECK:
                        if (abort_w)
                            st_q <= ST_IDLE;
                        else if (chk_done)
                        begin
                            if (chk_hash == addr_lo_q[23:0])
                            begin
                                status_q <= key_idx_q;
                                ev_set_q[EV_MATCH_BIT] <= 1'b1;
                                ev_set_q[EV_DONE_BIT] <= 1'b1;
                                st_q <= ST_IDLE;
                            end
                            else if ({1'b0, key_idx_q} == keys_eff - 5'h01)
                            begin
                                ev_set_q[EV_NOMATCH_BIT] <= 1'b1;
                                ev_set_q[EV_DONE_BIT] <= 1'b1;
                                st_q <= ST_IDLE;
                            end
                            else
                            begin
                                key_idx_q <= key_idx_q + 4'h1;
                                st_q <= ST_RD_KEY;
                            end
                        end
                    default: ;
                endcase
            end
        end
    end

    // Per-key and whole-run cycle counts, watched by the timing checks
    always_ff @(posedge clk_i)
    begin
        if (rst_i || st_q == ST_IDLE)
        begin
            key_cyc_q <= 16'h0000;
            run_cyc_q <= 16'h0000;
        end
        else
        begin
            run_cyc_q <= run_cyc_q + 16'h0001;
            if (st_q == ST_CHECK && chk_done)
                key_cyc_q <= 16'h0000;
            else if (st_q == ST_RD_KEY || st_q == ST_CHECK)
                key_cyc_q <= key_cyc_q + 16'h0001;
        end
    end

    assign mp.req = req_q;
    assign mp.we = we_q;
    assign mp.sel = sel_q;
    assign mp.addr = addr_q;
    assign mp.wdata = wdata_q;

    par_mem_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mp(mp),
        .mem_cyc_o(mem_cyc_o),
        .mem_we_o(mem_we_o),
        .mem_sel_o(mem_sel_o),
        .mem_adr_o(mem_adr_o),
        .mem_dat_o(mem_dat_o),
        .mem_ack_i(mem_ack_i),
        .mem_dat_i(mem_dat_i)
    );

    par_key_check #(.ROUNDS(KEY_ROUNDS)) u_check (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(chk_start_q),
        .key_i({kw_q[3], kw_q[2], kw_q[1], kw_q[0]}),
        .prand_i(prand),
        .done_o(chk_done),
        .hash_o(chk_hash)
    );

    // Checks on the sequencer and registers
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_taken;
        st_q == ST_IDLE && start_w && run_en;
    endsequence

    a_disable_clears_mask: assert property (
        wr_en && wb_sel_i[0] && hit(wb_adr_i, OFS_INT_DIS) |=> (mask_q & $past(wb_dat_i[2:0])) == 3'h0)
        else $error("disable write left an interrupt armed");
    a_arm_sets_mask: assert property (
        wr_en && wb_sel_i[0] && hit(wb_adr_i, OFS_INT_ARM)
        |=> mask_q == ($past(mask_q) | $past(wb_dat_i[2:0])))
        else $error("arm write did not set exactly the written bits");
    a_status_on_match: assert property (
        !$stable(status_q) |-> $past(st_q) == ST_CHECK && ev_set_q[EV_MATCH_BIT])
        else $error("status changed without a match");
    a_key_index_bound: assert property (
        st_q == ST_RD_KEY |-> {1'b0, key_idx_q} < keys_eff)
        else $error("key walk ran past the key count");
    a_key_fetch_addr: assert property (
        s_start_taken ##1 (st_q == ST_RD_ADDR0) [*1] ##[1:300] (req_q && st_q == ST_RD_KEY
        && key_idx_q == 4'h0 && word_idx_q == 2'h0)
        |-> addr_q == key_ptr_q)
        else $error("first key word not read at key table pointer");
    a_target_read: assert property (
        s_start_taken |=> ##1 req_q && !we_q && addr_q == addr_ptr_q)
        else $error("resolution did not begin at the target address");
    a_work_write: assert property (
        req_q && we_q |-> addr_q == work_ptr_q && sel_q == WORK_SEL)
        else $error("write outside the three-byte work area");
    a_key_time: assert property (
        key_cyc_q <= 16'(KEY_CYC)
        && run_cyc_q <= {11'h000, keys_eff} * 16'(KEY_CYC) + 16'(OVH_CYC))
        else $error("resolution exceeded its time budget");
    a_done_with_result: assert property (
        $rose(ev_set_q[EV_MATCH_BIT]) || $rose(ev_set_q[EV_NOMATCH_BIT])
        |-> ev_set_q[EV_DONE_BIT] && st_q == ST_IDLE)
        else $error("result event without done event");
    a_no_access_disabled: assert property (
        req_q |-> $past(run_en))
        else $error("memory request while disabled");
endmodule

//--- testbench/par_mem_model.sv
// System memory beside the resolver: word array with slow and fast answers.
// Assumes byte addresses below 0x100 and one open cycle at a time.
`timescale 1ns/10ps
module par_mem_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o
);
    logic [31:0] mem [64];
    int n_acc;
    int wt;
    // Every other access waits three cycles; idle data toggles so stale reads show
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            wt <= 0;
            n_acc <= 0;
            dat_o <= 32'h0000_0000;
        end
        else if (cyc_i && !ack_o && wt < (n_acc % 2) * 3)
            wt <= wt + 1;
        else if (cyc_i && !ack_o)
        begin
            ack_o <= 1'b1;
            wt <= 0;
            n_acc <= n_acc + 1;
            dat_o <= mem[adr_i[7:2]];
            for (int b = 0; b < 4; b++)
                if (we_i && sel_i[b])
                    mem[adr_i[7:2]][8*b+:8] <= dat_i[8*b+:8];
        end
        else
        begin
            ack_o <= 1'b0;
            dat_o <= ~dat_o;
        end
    end
endmodule

//--- testbench/tb_top.sv
// Register-level tests of the resolver over classic Wishbone.
// Assumes the memory model sits on the resolver's memory master port.
`timescale 1ns/10ps
module tb_top;
    import par_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] q, rdat, m_adr, m_wd, m_rd;
    logic ack, irq_o, m_cyc, m_we, m_ack;
    logic [3:0] m_sel;
    int miscompares = 0;
    int n_tests = 0;
    int cnt;
    logic [23:0] pr = 24'h5a3c96;
    always #12.5 clk_i = ~clk_i;
    par_resolver i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq_o), .mem_cyc_o(m_cyc), .mem_we_o(m_we), .mem_sel_o(m_sel),
        .mem_adr_o(m_adr), .mem_dat_o(m_wd), .mem_ack_i(m_ack), .mem_dat_i(m_rd));
    par_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .we_i(m_we),
        .sel_i(m_sel), .adr_i(m_adr), .dat_i(m_wd), .ack_o(m_ack), .dat_o(m_rd));
    // Stand-in keyed mix, rebuilt here so the match key can be planted
    function automatic logic [23:0] hsh(input logic [127:0] k);
        logic [31:0] s;
        s = {8'h00, pr} ^ k[31:0];
        for (int r = 0; r < CHECK_ROUNDS; r++)
            s = {s[26:0], s[31:27]} + (s ^ k[32*(r%4)+:32]);
        return s[23:0];
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {20'h00000, a};
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), q, e);
    endtask
    // Start, wait for the interrupt, then check time and memory traffic
    task automatic run(input int k, input int acc);
        wr(OFS_START, 32'h1);
        cnt = 0;
        while (irq_o !== 1'b1 && cnt < 2000)
        begin
            @(posedge clk_i);
            cnt++;
        end
        chk("res_time", cnt <= OVH_CYC + KEY_CYC * k, 32'h1);
        chk("mem_acc", i_mem.n_acc, acc);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial
    begin
        #(25 * 20000);
        miscompares++;
        stop_test;
    end
    initial
    begin
        for (int i = 0; i < 64; i++)
            i_mem.mem[i] = 32'h0000_0000;
        i_mem.mem[8] = 32'hee00_0000; // Top byte must survive the 3-byte write
        i_mem.mem[16] = 32'h1;
        i_mem.mem[20] = 32'h2;
        i_mem.mem[32] = {pr[7:0], hsh(128'h2)};
        i_mem.mem[33] = {16'h0000, pr[23:8]};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_KEY_COUNT, 32'h1);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_INT_DIS, 32'h0);
        $display("test reset done");
        wr(OFS_INT_ARM, 32'h7);
        rd(OFS_INT_DIS, 32'h7);
        wr(OFS_INT_DIS, 32'h1);
        rd(OFS_INT_DIS, 32'h6);
        wr(OFS_INT_ARM, 32'h0);
        rd(OFS_INT_DIS, 32'h6);
        $display("test mask done");
        wr(OFS_START, 32'h1);
        repeat (40) @(posedge clk_i);
        chk("mem_acc", i_mem.n_acc, 32'h0);
        rd(OFS_EV_DONE, 32'h0);
        $display("test disabled done");
        wr(OFS_KEY_PTR, 32'h40);
        wr(OFS_ADDR_PTR, 32'h80);
        wr(OFS_WORK_PTR, 32'h20);
        wr(OFS_KEY_COUNT, 32'h2);
        wr(OFS_ENABLE, {30'h0, ENABLE_ON});
        wr(OFS_INT_ARM, 32'h1);
        run(2, 11);
        rd(OFS_STATUS, 32'h1);
        rd(OFS_EV_MATCH, 32'h1);
        rd(OFS_EV_DONE, 32'h1);
        chk("work", i_mem.mem[8], {8'hee, pr});
        wr(OFS_EV_DONE, 32'h1);
        wr(OFS_EV_MATCH, 32'h1);
        // Event clear, then the registered interrupt, each take one edge
        repeat (2) @(posedge clk_i);
        chk("irq", irq_o, 32'h0);
        $display("test match done");
        wr(OFS_KEY_COUNT, 32'h1);
        run(1, 18);
        rd(OFS_EV_NOMATCH, 32'h1);
        rd(OFS_EV_DONE, 32'h1);
        rd(OFS_EV_MATCH, 32'h0);
        $display("test no match done");
        // Disable lands while the first address read is open; nothing follows it
        wr(OFS_EV_DONE, 32'h1);
        wr(OFS_START, 32'h1);
        wr(OFS_ENABLE, 32'h0);
        repeat (40) @(posedge clk_i);
        chk("mem_acc", i_mem.n_acc, 32'h13);
        rd(OFS_EV_DONE, 32'h0);
        $display("test abort done");
        stop_test;
    end
endmodule
